// File: inc/mem_guard_pkg.sv
// Constants and types for the RAM/SFR guard and access checker.
// Assumes a 20-bit CPU address space and one AHB-Lite register slave.
package mem_guard_pkg;

    // Register byte addresses
    localparam logic [31:0] CTRL_ADDR = 32'h000f_0078;
    localparam logic [31:0] STAT_ADDR = 32'h000f_0080;
    localparam logic [31:0] MASK_ADDR = 32'h000f_0084;

    // Control register layout and reset
    localparam int EN_BIT = 7;
    localparam int RAMG_HI = 5;
    localparam int RAMG_LO = 4;
    localparam int PORTG_BIT = 2;
    localparam int IRQG_BIT = 1;
    localparam int SYSG_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hb7;

    // Event status bits
    localparam int EV_RAM = 0;
    localparam int EV_SFR = 1;
    localparam int EV_INV = 2;
    localparam int EV_N = 3;

    // Address map
    localparam logic [19:0] SFR_LO = 20'hfff00;
    localparam logic [19:0] GPR_LO = 20'hffee0;
    localparam logic [19:0] GPR_HI = 20'hffeff;
    localparam logic [19:0] RSV_HI_LO = 20'hf4000;
    localparam logic [19:0] MIR_LO = 20'hf2000;
    localparam logic [19:0] MIR_HI = 20'hf3fff;
    localparam logic [19:0] DFL_LO = 20'hf1000;
    localparam logic [19:0] DFL_HI = 20'hf17ff;
    localparam logic [19:0] SFR2_LO = 20'hf0000;
    localparam logic [19:0] SFR2_HI = 20'hf07ff;

    // Guard span sizes in bytes
    localparam logic [19:0] G128 = 20'h00080;
    localparam logic [19:0] G256 = 20'h00100;
    localparam logic [19:0] G512 = 20'h00200;

    typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} access_kind_type;

    // SFR group of the target, from the SFR address decoder
    typedef enum logic [2:0] {
        GRP_NONE, GRP_PORT_DATA, GRP_PORT_CFG, GRP_IRQ_CFG, GRP_SYSCTL_CFG
    } sfr_group_type;

    typedef struct packed {
        logic valid;
        access_kind_type kind;
        logic [19:0] addr;
        sfr_group_type group;
    } cpu_access_type;

endpackage

// File: design/ram_sfr_guard_access_check.sv
// RAM/SFR write guard and invalid access detector with AHB-Lite registers.
// Assumes the CPU presents one access per cycle and obeys wr_allow_o.
`timescale 1ns/100ps
module ram_sfr_guard_access_check
    import mem_guard_pkg::*;
#(
    parameter int RAM_BYTES = 2048,
    parameter int FLASH_BYTES = 16384
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // CPU access check
    input wire cpu_access_type cpu_i,
    input wire logic watchdog_option_on_i,
    output logic wr_allow_o,
    output logic access_reset_o,
    // Interrupt
    output logic irq_o
);

    localparam logic [19:0] RAM_LO = 20'(SFR_LO - 20'(RAM_BYTES));
    localparam logic [19:0] FL_HI = 20'(FLASH_BYTES - 1);

    logic [7:0] ctrl_r;
    logic [EV_N-1:0] stat_r;
    logic [EV_N-1:0] mask_r;
    logic wr_pend_r;
    logic [31:0] dp_addr_r;
    logic access_reset_r;

    // Inclusive address range test
    function automatic logic in_rng(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // Span guarded by the size field
    function automatic logic [19:0] guard_len(input logic [1:0] f);
        case (f)
            2'b01: guard_len = G128;
            2'b10: guard_len = G256;
            2'b11: guard_len = G512;
            default: guard_len = 20'h00000;
        endcase
    endfunction

    // Address map decode
    logic [19:0] a;
    logic is_wr;
    logic is_fetch;
    logic in_sfr;
    logic in_gpr;
    logic in_ram;
    logic in_mir;
    logic in_dfl;
    logic in_sfr2;
    logic in_code;
    logic in_flash;
    logic invalid;
    logic detect_on;

    assign a = cpu_i.addr;
    assign is_wr = cpu_i.kind == ACC_WRITE;
    assign is_fetch = cpu_i.kind == ACC_FETCH;
    assign in_sfr = a >= SFR_LO;
    assign in_gpr = in_rng(a, GPR_LO, GPR_HI);
    assign in_ram = in_rng(a, RAM_LO, 20'(GPR_LO - 20'h00001));
    assign in_mir = in_rng(a, MIR_LO, MIR_HI);
    assign in_dfl = in_rng(a, DFL_LO, DFL_HI);
    assign in_sfr2 = in_rng(a, SFR2_LO, SFR2_HI);
    assign in_code = a <= FL_HI;
    assign in_flash = in_code || in_mir || in_dfl;

    // Anything unmapped is reserved for every access kind
    always_comb begin
        invalid = 1'b0;
        if (!(in_sfr || in_gpr || in_ram || in_flash || in_sfr2)) begin
            invalid = 1'b1;
        end else if (is_fetch && (in_sfr || in_sfr2 || in_dfl)) begin
            invalid = 1'b1;
        end else if (is_wr && in_flash) begin
            invalid = 1'b1;
        end
    end

    // Watchdog option forces detection on
    assign detect_on = ctrl_r[EN_BIT] || watchdog_option_on_i;

    // RAM guard span, the register bank excluded
    logic [19:0] g_len;
    logic ram_block;

    assign g_len = guard_len(ctrl_r[RAMG_HI:RAMG_LO]);
    // Span kept inside RAM, so a wide code on a small RAM never reaches the SFRs
    assign ram_block = is_wr && !in_gpr
        && in_ram && (20'(a - RAM_LO) < g_len);

    // SFR group guards; port data is never a guarded group
    logic sfr_block;

    always_comb begin
        sfr_block = 1'b0;
        if (is_wr) begin
            case (cpu_i.group)
                GRP_PORT_CFG: sfr_block = ctrl_r[PORTG_BIT];
                GRP_IRQ_CFG: sfr_block = ctrl_r[IRQG_BIT];
                GRP_SYSCTL_CFG: sfr_block = ctrl_r[SYSG_BIT];
                GRP_PORT_DATA: sfr_block = 1'b0;
                default: sfr_block = 1'b0;
            endcase
        end
    end

    // Write strobe gate; a blocked write simply does not land
    assign wr_allow_o = cpu_i.valid && is_wr && !ram_block
        && !sfr_block && !invalid;

    // Reset request one cycle after the offending access
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            access_reset_r <= 1'b0;
        end else begin
            access_reset_r <= cpu_i.valid && invalid && detect_on;
        end
    end

    assign access_reset_o = access_reset_r;

    // AHB address phase capture; zero wait states
    logic take;

    assign take = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_pend_r <= 1'b0;
            dp_addr_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= take && hwrite_i;
            if (take) begin
                dp_addr_r <= haddr_i;
            end
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    assign wr_ctrl = wr_pend_r && dp_addr_r == CTRL_ADDR;
    assign wr_stat = wr_pend_r && dp_addr_r == STAT_ADDR;
    assign wr_mask = wr_pend_r && dp_addr_r == MASK_ADDR;

    // Control register; enable bit can only be set by software
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctrl) begin
            // Whole low byte taken at once; bits 6 and 3 forced low
            ctrl_r <= hwdata_i[7:0] & CTRL_WMASK;
            ctrl_r[EN_BIT] <= ctrl_r[EN_BIT] | hwdata_i[EN_BIT];
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    logic [EV_N-1:0] ev;

    assign ev[EV_RAM] = cpu_i.valid && ram_block && !invalid;
    assign ev[EV_SFR] = cpu_i.valid && sfr_block && !invalid;
    assign ev[EV_INV] = cpu_i.valid && invalid && !detect_on;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~(wr_stat ? hwdata_i[EV_N-1:0] : '0)) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mask_r <= '0;
        end else if (wr_mask) begin
            mask_r <= hwdata_i[EV_N-1:0];
        end
    end

    assign irq_o = |(stat_r & mask_r);

    // Read mux on the data-phase address; unmapped reads give zero
    always_comb begin
        hrdata_o = 32'h0000_0000;
        case (dp_addr_r)
            CTRL_ADDR: hrdata_o[7:0] = ctrl_r;
            STAT_ADDR: hrdata_o[EV_N-1:0] = stat_r;
            MASK_ADDR: hrdata_o[EV_N-1:0] = mask_r;
            default: hrdata_o = 32'h0000_0000;
        endcase
    end

    // Checks
    a_ctrl_reset_zero: assert property (@(posedge clk_i)
        srst_i |=> ctrl_r == CTRL_RST)
        else $error("control not cleared by reset");

    a_enable_stays_set: assert property (@(posedge clk_i)
        disable iff (srst_i) ctrl_r[EN_BIT] |=> ctrl_r[EN_BIT])
        else $error("detection enable dropped");

    a_fixed_zero_bits: assert property (@(posedge clk_i)
        disable iff (srst_i) !ctrl_r[6] && !ctrl_r[3])
        else $error("fixed zero bit set");

    a_ram_write_drop: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && ctrl_r[RAMG_HI:RAMG_LO] == 2'b01
        && in_rng(a, RAM_LO, 20'(RAM_LO + 20'h0007f)) && !in_gpr
        |-> !wr_allow_o)
        else $error("guarded RAM write passed");

    a_gpr_write_ok: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && in_gpr && cpu_i.group == GRP_NONE
        |-> wr_allow_o)
        else $error("register bank write blocked");

    a_port_cfg_drop: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && cpu_i.group == GRP_PORT_CFG
        && ctrl_r[PORTG_BIT] |-> !wr_allow_o)
        else $error("port config write passed");

    a_port_data_ok: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && cpu_i.group == GRP_PORT_DATA && in_sfr
        |-> wr_allow_o)
        else $error("port data write blocked");

    a_irq_cfg_drop: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && cpu_i.group == GRP_IRQ_CFG
        && ctrl_r[IRQG_BIT] |-> !wr_allow_o)
        else $error("interrupt config write passed");

    a_sys_cfg_drop: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && cpu_i.group == GRP_SYSCTL_CFG
        && ctrl_r[SYSG_BIT] |-> !wr_allow_o)
        else $error("system config write passed");

    a_invalid_resets: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_fetch && in_sfr && ctrl_r[EN_BIT]
        |=> access_reset_o)
        else $error("invalid fetch gave no reset");

    a_watchdog_detect: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && is_wr && in_code && watchdog_option_on_i
        |=> access_reset_o)
        else $error("watchdog option did not force detection");

    a_guard_no_reset: assert property (@(posedge clk_i)
        disable iff (srst_i)
        cpu_i.valid && (ram_block || sfr_block) && !invalid
        |=> !access_reset_o)
        else $error("guarded write caused reset");

endmodule

// File: bench/cpu_access_model.sv
// CPU core model: one fetch, read or write per call, answers sampled back.
// Assumes the caller is just past a rising edge when it calls.
`timescale 1ns/100ps
module cpu_access_model
    import mem_guard_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Checker answers
    input wire logic wr_allow_i,
    input wire logic access_reset_i,
    // Access request
    output cpu_access_type cpu_o
);
    // Idle at time zero
    initial cpu_o = '{valid: 1'b0, kind: ACC_READ, addr: 20'h00000, group: GRP_NONE};

    // One-cycle access; idle afterwards shows the inverse address, never a stale one
    task automatic access(input access_kind_type k, input logic [19:0] a, input sfr_group_type g,
                          output logic allow, output logic rst);
        cpu_o <= '{valid: 1'b1, kind: k, addr: a, group: g};
        @(negedge clk_i);
        allow = wr_allow_i;
        @(posedge clk_i);
        #1;
        rst = access_reset_i;
        cpu_o <= '{valid: 1'b0, kind: ACC_READ, addr: ~a, group: GRP_NONE};
        // One idle edge, so a following call never reassigns cpu_o in this time step
        @(posedge clk_i);
        #1;
    endtask
endmodule

// File: bench/ram_sfr_guard_access_check_tb.sv
// Self-checking bench for the RAM/SFR guard: AHB-Lite tasks plus a CPU model.
// Assumes zero or more wait states; small RAM and flash sizes set by parameter.
`timescale 1ns/100ps
module ram_sfr_guard_access_check_tb import mem_guard_pkg::*;;
    localparam int RAMB = 512;
    localparam logic [19:0] RBASE = 20'hfff00 - 20'(RAMB);
    logic clk_i, srst_i, hsel, hwrite, wdog, al, rs, rdy_s, hready, hresp, wr_allow, acc_rst, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd_s, q;
    int miscompares, tests_run, cycles;
    cpu_access_type cpu;
    // Widest span on this RAM size stops at the register bank, which stays writable
    logic [19:0] lim [4] = '{20'h00080, 20'h00080, 20'h00100, 20'h001e0};
    sfr_group_type grp [4] = '{GRP_PORT_DATA, GRP_PORT_CFG, GRP_IRQ_CFG, GRP_SYSCTL_CFG};
    sfr_group_type gb [3] = '{GRP_SYSCTL_CFG, GRP_IRQ_CFG, GRP_PORT_CFG};
    access_kind_type ik [11] = '{ACC_FETCH, ACC_READ, ACC_WRITE, ACC_FETCH, ACC_WRITE, ACC_FETCH,
                                 ACC_WRITE, ACC_READ, ACC_FETCH, ACC_WRITE, ACC_READ};
    logic [19:0] ia [11] = '{20'hfff10, 20'h10000, 20'h00010, 20'hf1000, 20'hf2000, 20'h00800,
                             20'hf4000, 20'h00010, 20'h007ff, RBASE, 20'hf2000};
    logic ie [11] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    ram_sfr_guard_access_check #(.RAM_BYTES(RAMB), .FLASH_BYTES(2048)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cpu_i(cpu),
        .watchdog_option_on_i(wdog), .wr_allow_o(wr_allow), .access_reset_o(acc_rst), .irq_o(irq));

    cpu_access_model cpu_m (.clk_i(clk_i), .wr_allow_i(wr_allow), .access_reset_i(acc_rst), .cpu_o(cpu));

    // Free-running 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Bus answers captured at the edge, so the data phase value is never raced
    always @(posedge clk_i) begin
        rdy_s <= hready;
        rd_s <= hrdata;
    end

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Single whole-word transfer; caller stands just past a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do begin @(posedge clk_i); #1; end while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clk_i); #1; end while (rdy_s !== 1'b1);
        r = rd_s;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r, exp);
    endtask

    task automatic do_reset;
        srst_i <= 1'b1;
        repeat (2) begin @(posedge clk_i); #1; end
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic test_done;
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        srst_i = 1'b1; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; wdog = 1'b0; miscompares = 0; tests_run = 0; cycles = 0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        rd(CTRL_ADDR, 32'h00000000);
        check({31'h0, hresp}, 32'h0);
        wr(CTRL_ADDR, 32'h000000ff);
        rd(CTRL_ADDR, 32'h000000b7);
        wr(CTRL_ADDR, 32'h00000000);
        rd(CTRL_ADDR, 32'h00000080);
        do_reset;
        rd(CTRL_ADDR, 32'h00000000);
        // Last guarded byte and first free byte for size codes 01 to 11; with code 00 both bytes pass
        for (int g = 0; g < 4; g++) begin
            wr(CTRL_ADDR, 32'(g) << RAMG_LO);
            cpu_m.access(ACC_WRITE, RBASE + lim[g] - 20'h1, GRP_NONE, al, rs);
            check({31'h0, al}, {31'h0, g == 0});
            check({31'h0, rs}, 32'h0);
            cpu_m.access(ACC_WRITE, RBASE + lim[g], GRP_NONE, al, rs);
            check({31'h0, al}, 32'h1);
        end
        cpu_m.access(ACC_WRITE, GPR_LO, GRP_NONE, al, rs);
        check({31'h0, al}, 32'h1);
        rd(STAT_ADDR, 32'h00000001);
        // Each SFR guard bit against each register group
        for (int b = 0; b < 3; b++) begin
            wr(CTRL_ADDR, 32'h1 << b);
            for (int k = 0; k < 4; k++) begin
                cpu_m.access(ACC_WRITE, 20'hfff10, grp[k], al, rs);
                check({31'h0, al}, {31'h0, grp[k] != gb[b]});
                check({31'h0, rs}, 32'h0);
            end
        end
        rd(STAT_ADDR, 32'h00000003);
        wr(STAT_ADDR, 32'h00000003);
        rd(STAT_ADDR, 32'h00000000);
        // Interrupt raised, masked and cleared
        wr(MASK_ADDR, 32'h00000002);
        check({31'h0, irq}, 32'h0);
        cpu_m.access(ACC_WRITE, 20'hfff10, GRP_PORT_CFG, al, rs);
        @(posedge clk_i);
        #1;
        check({31'h0, irq}, 32'h1);
        wr(MASK_ADDR, 32'h00000000);
        check({31'h0, irq}, 32'h0);
        wr(MASK_ADDR, 32'h00000002);
        wr(STAT_ADDR, 32'h00000002);
        check({31'h0, irq}, 32'h0);
        wr(32'h000f0090, 32'h000000ff);
        rd(32'h000f0090, 32'h00000000);
        rd(CTRL_ADDR, 32'h00000004);
        // Detection off: no reset, only the status bit
        cpu_m.access(ACC_FETCH, 20'hfff10, GRP_NONE, al, rs);
        check({31'h0, rs}, 32'h0);
        rd(STAT_ADDR, 32'h00000004);
        wr(CTRL_ADDR, 32'h00000080);
        for (int i = 0; i < 11; i++) begin
            cpu_m.access(ik[i], ia[i], GRP_NONE, al, rs);
            check({31'h0, rs}, {31'h0, ie[i]});
        end
        do_reset;
        // Code flash write with only the watchdog option forcing detection
        wdog <= 1'b1;
        cpu_m.access(ACC_WRITE, 20'h00010, GRP_NONE, al, rs);
        check({31'h0, rs}, 32'h1);
        wdog <= 1'b0;
        test_done;
    end
endmodule
